// file: hdl/rsx_regs.sv
// Receiver status, clock mode and transmit control registers of the transceiver.
// Assumes register accesses arrive as one-cycle read/write strobes from the
// serial control port logic, and that all datapath inputs share clock_i.
// Notes on behaviour
// - Parity or biphase error sets parity flag
// - Reading event status clears four event flags
// - Received channel-status change sets change flag
// - Stored subcode change sets subcode flag
// - Unlock bit reads 1 when PLL unlocked
// - Separate nonlinear and surround detect bits
// - Start ID flag sets, cleared by read
// - Emphasis from status bits, rate code upper
// - Status CRC error only professional, selected channel
// - Subcode CRC failure flag readable
// - Word clock sync only when enabled
// - Mode bit picks synchronous or asynchronous
// - Master clock outputs low when disabled
// - Inverted transmit output low when disabled
// - Validity bit inserted from control bit
// - Status CRC generated only professional and enabled
// - Rising copy bit copies all received status
// - Copied status used after next block start
// - Copy bit self-clears after copy completes
// - Channel select picks status source channel
// - Masked events do not drive interrupt pins
`timescale 1ns/1ps
`default_nettype none

module rsx_regs #(
    parameter int CS_BITS  = rsx_pkg::RSX_CS_BITS,  // Channel-status bits per block
    parameter int SUB_BITS = rsx_pkg::RSX_SUB_BITS  // Stored subcode bits
) (
    input  wire logic                clock_i,                 // 100 MHz master clock
    input  wire logic                reset_i,                 // Sync reset, active high
    input  wire logic [7:0]          reg_addr_i,              // Register address
    input  wire logic                reg_wr_i,                // Write strobe
    input  wire logic                reg_rd_i,                // Read strobe
    input  wire logic [7:0]          reg_wdata_i,             // Write data
    output logic      [7:0]          reg_rdata_o,             // Read data, registered
    input  wire logic                parity_err_i,            // Subframe parity error pulse
    input  wire logic                biphase_err_i,           // Biphase coding error pulse
    input  wire logic                invalid_i,               // Received validity bit
    input  wire logic                pll_locked_i,            // Receiver PLL lock
    input  wire logic                nonlinear_detect_i,      // Compressed stream seen
    input  wire logic                cd_surround_detect_i,    // CD surround stream seen
    input  wire logic                start_id_i,              // Tape start ID pulse
    input  wire logic [3:0]          fs_code_i,               // Detected rate code
    input  wire logic                rx_block_start_i,        // Receive block start pulse
    input  wire logic [CS_BITS-1:0]  cs_chan_a_i,             // Channel 1 status block
    input  wire logic [CS_BITS-1:0]  cs_chan_b_i,             // Channel 2 status block
    input  wire logic                cs_crc_err_a_i,          // Channel 1 status CRC bad
    input  wire logic                cs_crc_err_b_i,          // Channel 2 status CRC bad
    input  wire logic                subcode_load_i,          // New subcode frame pulse
    input  wire logic [SUB_BITS-1:0] subcode_i,               // Received subcode bytes
    input  wire logic                subcode_crc_err_i,       // Subcode CRC failed
    input  wire logic                status_channel_select_i, // 0 channel 1, 1 channel 2
    input  wire logic [7:0]          irq_mask_a_i,            // Mask for first irq pin
    input  wire logic [7:0]          irq_mask_b_i,            // Mask for second irq pin
    input  wire logic                mclk_a_i,                // Master clock A source
    input  wire logic                mclk_b_i,                // Master clock B source
    input  wire logic                tx_neg_i,                // Inverted transmit source
    input  wire logic                tx_block_start_i,        // Transmit block start pulse
    output logic                     irq_out_a_o,             // First interrupt pin
    output logic                     irq_out_b_o,             // Second interrupt pin
    output logic                     mclk_out_a_o,            // Gated master clock A
    output logic                     mclk_out_b_o,            // Gated master clock B
    output logic                     tx_diff_negative_o,      // Inverted transmit pin
    output logic                     word_clock_sync_enable_o,// Sync to ext word clock
    output logic                     mode_select_a_o,         // 1 asynchronous mode
    output logic                     crystal_select_o,        // Crystal select
    output logic                     pll_ref_select_o,        // PLL reference select
    output logic                     tx_validity_bit_o,       // Validity bit to send
    output logic                     tx_crc_gen_o,            // Generate status CRC
    output logic [1:0]               mode_select_a_iface_format_o,    // Mode_select_a interface format
    output logic [1:0]               ext_mclk_rate_o,         // External mclk rate
    output logic                     tx_mclk_source_o,        // TX master clock source
    output logic [CS_BITS-1:0]       tx_chan_status_bits_o    // Status bits being sent
);
    import rsx_pkg::*;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [7:0]          event_q, event_d;     // Event status: sticky and level flags
    logic                start_id_q, start_id_d; // Tape start-ID flag
    logic [3:0]          fs_q;                 // Last rate code seen
    logic                emph_q;               // Last emphasis state seen
    logic [7:0]          clk_mode_q;           // clock_mode_control
    logic [7:0]          tx_ctl_q;             // transmit_control
    logic [CS_BITS-1:0]  rx_chan_status_bits_q;// Received status buffer
    logic [SUB_BITS-1:0] subcode_q;            // Stored subcode
    logic [CS_BITS-1:0]  tx_pend_q;            // Copied, not yet in use
    logic                tx_pend_valid_q;      // A copy waits for block start
    logic [CS_BITS-1:0]  tx_chan_status_bits_q;// Status in use by transmitter
    logic [7:0]          rdata_q;              // Read data register

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    // Strobes qualified by address; each lasts one cycle, so a read
    // clears its flags exactly once however long the address stands
    wire rd_event  = reg_rd_i && (reg_addr_i == RSX_ADDR_EVENT_STATUS);
    wire rd_stream = reg_rd_i && (reg_addr_i == RSX_ADDR_STREAM_STATUS);
    wire wr_clk    = reg_wr_i && (reg_addr_i == RSX_ADDR_CLOCK_MODE);
    wire wr_tx     = reg_wr_i && (reg_addr_i == RSX_ADDR_TX_CONTROL);

    // Channel-status source, chosen by the select input
    wire [CS_BITS-1:0] cs_sel = status_channel_select_i ? cs_chan_b_i : cs_chan_a_i;
    wire cs_pro    = cs_sel[RSX_CS_PRO];
    wire cs_crc_sel = status_channel_select_i ? cs_crc_err_b_i : cs_crc_err_a_i;

    // Emphasis field sits at a different place in each status format
    wire emph_con = cs_sel[RSX_CON_EMPH_LO +: 3] == RSX_CON_EMPH_ON;
    wire emph_pro = cs_sel[RSX_PRO_EMPH_LO +: 3] == RSX_PRO_EMPH_ON;
    wire emph_now = cs_pro ? emph_pro : emph_con;

    // ------------------------------------------------------------
    // Event detection
    // ------------------------------------------------------------
    wire set_parity = parity_err_i || biphase_err_i;
    wire set_rate   = (fs_code_i != fs_q) || (emph_now != emph_q);
    wire set_cs     = rx_block_start_i && (cs_sel != rx_chan_status_bits_q);
    wire set_sub    = subcode_load_i && (subcode_i != subcode_q);

    // Sticky flags: a read clears, but a same-cycle event wins
    wire [7:0] ev_set = {set_sub, 1'b0, set_cs, 1'b0, 1'b0, set_rate, 1'b0, set_parity};
    wire [7:0] ev_clr = rd_event ? RSX_EV_CLR_MASK : 8'h00;
    wire [7:0] sticky = (event_q & ~ev_clr) | ev_set;

    // Level bits follow their sources directly
    always_comb begin
        event_d                   = sticky & RSX_EV_CLR_MASK;
        event_d[RSX_EV_NONAUDIO]  = cs_sel[RSX_CS_NONAUDIO];
        event_d[RSX_EV_INVALID]   = invalid_i;
        event_d[RSX_EV_UNLOCK]    = !pll_locked_i;
        event_d[RSX_EV_STREAM]    = nonlinear_detect_i || cd_surround_detect_i;
    end

    // Start ID clears on a stream-status read, again losing to a new event
    assign start_id_d = (start_id_q && !rd_stream) || start_id_i;

    // ------------------------------------------------------------
    // Status registers
    // ------------------------------------------------------------
    // Status flags and change trackers
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            event_q    <= 8'h00;
            start_id_q <= 1'b0;
            fs_q       <= RSX_FS_RESET;
            emph_q     <= 1'b0;
        end else begin
            event_q    <= event_d;
            start_id_q <= start_id_d;
            fs_q       <= fs_code_i;
            emph_q     <= emph_now;
        end
    end

    // Receive buffers; reset matters for the first comparison and for a copy taken before the first receive block start
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            rx_chan_status_bits_q <= '0;
            subcode_q             <= '0;
        end else begin
            if (rx_block_start_i) begin
                rx_chan_status_bits_q <= cs_sel;
            end
            if (subcode_load_i) begin
                subcode_q <= subcode_i;
            end
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    // Copy request: only a 0-to-1 change of the copy bit starts a copy
    wire copy_start = wr_tx && reg_wdata_i[RSX_TX_COPY] && !tx_ctl_q[RSX_TX_COPY];

    // Copy bit: set by the rising write, cleared once the copy has landed
    wire copy_bit_d = copy_start ? 1'b1
                    : tx_ctl_q[RSX_TX_COPY] ? 1'b0
                    : 1'b0;
    // A second write of 1 during the copy cycle cannot retrigger it; the
    // copy bit stands for exactly one cycle, so that window is short.

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            clk_mode_q <= RSX_CK_RESET;
            tx_ctl_q   <= RSX_TX_RESET;
        end else begin
            if (wr_clk) begin
                clk_mode_q <= reg_wdata_i & RSX_CK_WMASK;
            end
            if (wr_tx) begin
                tx_ctl_q <= reg_wdata_i;
            end
            tx_ctl_q[RSX_TX_COPY] <= copy_bit_d;
        end
    end

    // ------------------------------------------------------------
    // Transmit channel-status buffer
    // ------------------------------------------------------------
    // The copy takes one cycle; the transmitter keeps the old block until
    // the next block boundary so a block is never sent half old, half new.
    // A block start in the copy cycle itself is skipped; the pending copy
    // then waits for the following boundary.
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            tx_pend_q             <= {{(CS_BITS-8){1'b0}}, RSX_TX_CS0_RESET};
            tx_pend_valid_q       <= 1'b0;
            tx_chan_status_bits_q <= {{(CS_BITS-8){1'b0}}, RSX_TX_CS0_RESET};
        end else begin
            if (tx_ctl_q[RSX_TX_COPY]) begin
                tx_pend_q       <= rx_chan_status_bits_q;
                tx_pend_valid_q <= 1'b1;
            end else if (tx_block_start_i && tx_pend_valid_q) begin
                tx_chan_status_bits_q <= tx_pend_q;
                tx_pend_valid_q       <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Rate code and emphasis read their registered copies, so the rate
    // flag and the value that it announces appear in the same cycle.
    wire [7:0] stream_word = {fs_q, emph_q, start_id_q,
                              cd_surround_detect_i, nonlinear_detect_i};
    wire       cs_crc_flag = cs_pro && cs_crc_sel;
    wire [7:0] crc_word    = {6'h00, subcode_crc_err_i, cs_crc_flag};

    // Read mux; unmapped addresses read zero
    wire [7:0] rd_mux = (reg_addr_i == RSX_ADDR_EVENT_STATUS)  ? event_q
                      : (reg_addr_i == RSX_ADDR_STREAM_STATUS) ? stream_word
                      : (reg_addr_i == RSX_ADDR_CRC_STATUS)    ? crc_word
                      : (reg_addr_i == RSX_ADDR_CLOCK_MODE)    ? clk_mode_q
                      : (reg_addr_i == RSX_ADDR_TX_CONTROL)    ? tx_ctl_q
                      : 8'h00;

    // Read data is captured with the strobe and held until the next read
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            rdata_q <= 8'h00;
        end else if (reg_rd_i) begin
            rdata_q <= rd_mux;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rdata_o           = rdata_q;
    // Interrupt pins are level ORs of unmasked flags; a pin held by a
    // sticky flag drops only once the host reads the event register
    assign irq_out_a_o           = |(event_q & ~irq_mask_a_i);
    assign irq_out_b_o           = |(event_q & ~irq_mask_b_i);
    // Clock gating by AND; an enable change mid-high can shorten one pulse
    assign mclk_out_a_o          = mclk_a_i && clk_mode_q[RSX_CK_MCLK_A];
    assign mclk_out_b_o          = mclk_b_i && clk_mode_q[RSX_CK_MCLK_B];
    assign tx_diff_negative_o    = tx_neg_i && clk_mode_q[RSX_CK_TX_NEG];
    assign word_clock_sync_enable_o = clk_mode_q[RSX_CK_WCLK_SYNC];
    assign mode_select_a_o       = clk_mode_q[RSX_CK_MODE_SELECT_A];
    assign crystal_select_o      = clk_mode_q[RSX_CK_XTAL];
    assign pll_ref_select_o      = clk_mode_q[RSX_CK_PLL_REF];
    assign tx_validity_bit_o     = tx_ctl_q[RSX_TX_VALID];
    assign tx_crc_gen_o          = tx_ctl_q[RSX_TX_CRCGEN]
                                   && tx_chan_status_bits_q[RSX_CS_PRO];
    assign mode_select_a_iface_format_o  = tx_ctl_q[RSX_TX_FMT_LO +: 2];
    assign ext_mclk_rate_o       = tx_ctl_q[RSX_TX_RATE_LO +: 2];
    assign tx_mclk_source_o      = tx_ctl_q[RSX_TX_MSRC];
    assign tx_chan_status_bits_o = tx_chan_status_bits_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // All checks sample on the master clock and sleep while reset is high,
    // so a reset in mid-run never leaves a half-finished check behind
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);

    a_parity_sets: assert property (set_parity |=> event_q[RSX_EV_PARITY])
        else $error("parity event did not set flag");
    a_read_clears: assert property (
        rd_event && !set_parity && !set_rate && !set_cs && !set_sub
        |=> (event_q & RSX_EV_CLR_MASK) == 8'h00)
        else $error("event read did not clear flags");
    a_rate_change: assert property ($changed(fs_code_i) |=> event_q[RSX_EV_RATE])
        else $error("rate change not flagged");
    a_cs_change: assert property (set_cs |=> event_q[RSX_EV_CS_CHG])
        else $error("status change not flagged");
    a_sub_change: assert property (set_sub |=> event_q[RSX_EV_SUB_CHG])
        else $error("subcode change not flagged");
    a_unlock_bit: assert property (!pll_locked_i [*2] |-> event_q[RSX_EV_UNLOCK])
        else $error("unlock bit wrong");
    a_start_clear: assert property (
        rd_stream && !start_id_i |=> !start_id_q)
        else $error("start id flag not cleared");
    a_chan_status_crc_error_mode: assert property (!cs_pro |-> !crc_word[0])
        else $error("status CRC error outside professional mode");
    a_mclk_gate: assert property (!clk_mode_q[RSX_CK_MCLK_A] |-> !mclk_out_a_o)
        else $error("master clock A not held low");
    a_copy_done: assert property (
        copy_start |=> tx_ctl_q[RSX_TX_COPY] ##1 !tx_ctl_q[RSX_TX_COPY])
        else $error("copy bit did not self-clear");
    a_copy_wait: assert property (
        !tx_block_start_i && !reset_i |=> $stable(tx_chan_status_bits_q))
        else $error("transmit status changed outside block start");
    a_event_wins: assert property (
        rd_event && set_parity |=> event_q[RSX_EV_PARITY])
        else $error("event lost to clearing read");

    // Read-only views and output gates
    a_emph_change: assert property ((emph_now != emph_q) |=> event_q[RSX_EV_RATE])
        else $error("emphasis change not flagged");
    a_stream_bits: assert property (
        rd_stream |=> reg_rdata_o[0] == $past(nonlinear_detect_i))
        else $error("stream detect bit wrong");
    a_sub_crc_bit: assert property (
        reg_rd_i && (reg_addr_i == RSX_ADDR_CRC_STATUS)
        |=> reg_rdata_o[1] == $past(subcode_crc_err_i))
        else $error("subcode CRC bit wrong");
    a_neg_gate: assert property (!clk_mode_q[RSX_CK_TX_NEG] |-> !tx_diff_negative_o)
        else $error("inverted transmit pin not held low");
    a_mclk_b_gate: assert property (!clk_mode_q[RSX_CK_MCLK_B] |-> !mclk_out_b_o)
        else $error("master clock B not held low");
    a_crc_gen_mode: assert property (
        !tx_chan_status_bits_o[RSX_CS_PRO] |-> !tx_crc_gen_o)
        else $error("status CRC generated in consumer mode");
    a_reserved_zero: assert property ((clk_mode_q & ~RSX_CK_WMASK) == 8'h00)
        else $error("reserved clock mode bit set");

    c_copy_path: cover property (copy_start ##[1:20] tx_block_start_i && tx_pend_valid_q);
    c_read_clear: cover property (event_q[RSX_EV_PARITY] && rd_event);
    c_irq_a: cover property (irq_out_a_o);
    c_set_wins: cover property (rd_event && set_sub);
    c_prof_crc: cover property (cs_pro && cs_crc_sel);

endmodule

`default_nettype wire

// file: include/rsx_pkg.sv
// Package for the receiver status / transmit control register slice.
// Assumes a host serial control port already decoded to byte-wide register accesses.
package rsx_pkg;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] RSX_ADDR_EVENT_STATUS  = 8'h07; // receiver_event_status
    localparam logic [7:0] RSX_ADDR_STREAM_STATUS = 8'h08; // receiver_stream_status
    localparam logic [7:0] RSX_ADDR_CRC_STATUS    = 8'h09; // receiver_crc_status
    localparam logic [7:0] RSX_ADDR_CLOCK_MODE    = 8'h0A; // clock_mode_control
    localparam logic [7:0] RSX_ADDR_TX_CONTROL    = 8'h0B; // transmit_control

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    // receiver_event_status
    localparam int RSX_EV_PARITY   = 0;
    localparam int RSX_EV_NONAUDIO = 1;
    localparam int RSX_EV_RATE     = 2;
    localparam int RSX_EV_INVALID  = 3;
    localparam int RSX_EV_UNLOCK   = 4;
    localparam int RSX_EV_CS_CHG   = 5;
    localparam int RSX_EV_STREAM   = 6;
    localparam int RSX_EV_SUB_CHG  = 7;
    // Bits cleared by a read of receiver_event_status
    localparam logic [7:0] RSX_EV_CLR_MASK = 8'hA5;
    // clock_mode_control
    localparam int RSX_CK_PLL_REF  = 0;
    localparam int RSX_CK_XTAL     = 1;
    localparam int RSX_CK_WCLK_SYNC = 2;
    localparam int RSX_CK_MODE_SELECT_A    = 3;
    localparam int RSX_CK_MCLK_A   = 4;
    localparam int RSX_CK_MCLK_B   = 5;
    localparam int RSX_CK_TX_NEG   = 7;
    localparam logic [7:0] RSX_CK_WMASK = 8'hBF;  // Bit 6 is reserved
    // transmit_control
    localparam int RSX_TX_VALID    = 0;
    localparam int RSX_TX_CRCGEN   = 1;
    localparam int RSX_TX_COPY     = 2;
    localparam int RSX_TX_FMT_LO   = 3;
    localparam int RSX_TX_RATE_LO  = 5;
    localparam int RSX_TX_MSRC     = 7;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RSX_CK_RESET      = 8'hB0;
    localparam logic [7:0] RSX_TX_RESET      = 8'h32;
    localparam logic [3:0] RSX_FS_RESET      = 4'h1;
    localparam logic [7:0] RSX_TX_CS0_RESET  = 8'h04;

    // ------------------------------------------------------------
    // Channel-status decoding
    // ------------------------------------------------------------
    localparam int RSX_CS_BITS     = 192;
    localparam int RSX_SUB_BITS    = 80;
    localparam int RSX_CS_PRO      = 0;    // Professional-mode bit
    localparam int RSX_CS_NONAUDIO = 1;
    localparam int RSX_CON_EMPH_LO = 3;    // Consumer emphasis field, 3 bits
    localparam int RSX_PRO_EMPH_LO = 2;    // Professional emphasis field, 3 bits
    localparam logic [2:0] RSX_CON_EMPH_ON = 3'h1;
    localparam logic [2:0] RSX_PRO_EMPH_ON = 3'h6;

endpackage

// file: verif/rsx_host.sv
// Host model: byte reads and writes through the decoded control port.
// Assumes one clock shared with the register slice.
`timescale 1ns/1ps
`default_nettype none
module rsx_host (
    input  wire logic       clock_i,  // Master clock
    input  wire logic [7:0] rdata_i,  // Read data from slice
    output logic      [7:0] addr_o,   // Register address
    output logic      [7:0] wdata_o,  // Write data
    output logic            wr_o,     // Write strobe
    output logic            rd_o      // Read strobe
);
    initial {addr_o, wdata_o, wr_o, rd_o} = '0;
    // One-cycle strobe; idle bus shows inverted values, never stale ones
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr_o  <= a;
        wdata_o <= d;
        wr_o    <= 1'b1;
        @(posedge clock_i);
        wr_o    <= 1'b0;
        addr_o  <= ~a;
        wdata_o <= ~d;
    endtask
    // Data lands one cycle after the read edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock_i);
        addr_o <= a;
        rd_o   <= 1'b1;
        @(posedge clock_i);
        rd_o   <= 1'b0;
        addr_o <= ~a;
        @(negedge clock_i);
        d = rdata_i;
    endtask
endmodule
`default_nettype wire

// file: verif/receiver_status_tx_control_regs_tb.sv
// Testbench for the register slice, driven through the host model.
// Assumes the package is compiled first.
`timescale 1ns/1ps
`default_nettype none
module receiver_status_tx_control_regs_tb;
    import rsx_pkg::*;
    logic clock_i = 1'b0, reset_i = 1'b1;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, irq_mask_a_i, irq_mask_b_i, rv;
    logic reg_wr_i, reg_rd_i, parity_err_i, biphase_err_i, invalid_i, pll_locked_i;
    logic nonlinear_detect_i, cd_surround_detect_i, start_id_i, rx_block_start_i;
    logic [3:0] fs_code_i;
    logic [191:0] cs_chan_a_i, cs_chan_b_i, tx_chan_status_bits_o;
    logic cs_crc_err_a_i, cs_crc_err_b_i, subcode_load_i, subcode_crc_err_i;
    logic [79:0] subcode_i;
    logic status_channel_select_i, mclk_a_i, mclk_b_i, tx_neg_i, tx_block_start_i;
    logic irq_out_a_o, irq_out_b_o, mclk_out_a_o, mclk_out_b_o, tx_diff_negative_o;
    logic word_clock_sync_enable_o, mode_select_a_o, crystal_select_o, pll_ref_select_o;
    logic tx_validity_bit_o, tx_crc_gen_o, tx_mclk_source_o;
    logic [1:0] mode_select_a_iface_format_o, ext_mclk_rate_o;
    int err_total = 0, samples_checked = 0, cyc = 0;
    rsx_regs dut (.*);
    rsx_host host (.clock_i(clock_i), .rdata_i(reg_rdata_o), .addr_o(reg_addr_i),
        .wdata_o(reg_wdata_i), .wr_o(reg_wr_i), .rd_o(reg_rd_i));
    always #5 clock_i = ~clock_i;
    // Hang guard: well beyond the fewer than one hundred cycles the tests need
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            tally_and_finish;
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, rv);
        chk(rv, e);
    endtask
    task automatic t_events;
        @(posedge clock_i);
        irq_mask_a_i  <= 8'hFE;
        biphase_err_i <= 1'b1;
        start_id_i    <= 1'b1;
        @(posedge clock_i);
        biphase_err_i <= 1'b0;
        start_id_i    <= 1'b0;
        @(negedge clock_i);
        chk({6'h0, irq_out_a_o, irq_out_b_o}, 8'h02);
        rchk(RSX_ADDR_EVENT_STATUS, 8'h01);
        rchk(RSX_ADDR_EVENT_STATUS, 8'h00);
        rchk(RSX_ADDR_STREAM_STATUS, 8'h14);
        rchk(RSX_ADDR_STREAM_STATUS, 8'h10);
        @(posedge clock_i);
        pll_locked_i <= 1'b0;
        rchk(RSX_ADDR_EVENT_STATUS, 8'h10);
        chk({7'h0, irq_out_a_o}, 8'h00);
        @(posedge clock_i);
        pll_locked_i <= 1'b1;
        $display("events test done");
    endtask
    task automatic t_clock;
        host.wr(RSX_ADDR_CLOCK_MODE, 8'hFF);
        rchk(RSX_ADDR_CLOCK_MODE, 8'hBF);
        chk({6'h0, mode_select_a_o, word_clock_sync_enable_o}, 8'h03);
        chk({6'h0, crystal_select_o, pll_ref_select_o}, 8'h03);
        host.wr(RSX_ADDR_CLOCK_MODE, 8'h00);
        @(negedge clock_i);
        chk({5'h0, mclk_out_a_o, mclk_out_b_o, tx_diff_negative_o}, 8'h00);
        host.wr(RSX_ADDR_CLOCK_MODE, RSX_CK_RESET);
        @(negedge clock_i);
        chk({5'h0, mclk_out_a_o, mclk_out_b_o, tx_diff_negative_o}, 8'h07);
        host.wr(RSX_ADDR_EVENT_STATUS, 8'hFF);
        rchk(RSX_ADDR_EVENT_STATUS, 8'h00);
        rchk(8'h30, 8'h00);
        $display("clock test done");
    endtask
    task automatic t_copy;
        @(posedge clock_i);
        cs_chan_a_i      <= {8'hC3, 176'h0, 8'h5A};
        rx_block_start_i <= 1'b1;
        @(posedge clock_i);
        rx_block_start_i <= 1'b0;
        rchk(RSX_ADDR_EVENT_STATUS, 8'h22);
        host.wr(RSX_ADDR_TX_CONTROL, 8'h37);
        rchk(RSX_ADDR_TX_CONTROL, 8'h33);
        chk(tx_chan_status_bits_o[7:0], 8'h04);
        chk({7'h0, tx_validity_bit_o}, 8'h01);
        chk({2'h0, mode_select_a_iface_format_o, ext_mclk_rate_o, tx_mclk_source_o,
            tx_validity_bit_o}, 8'h25);
        @(posedge clock_i);
        tx_block_start_i <= 1'b1;
        @(posedge clock_i);
        tx_block_start_i <= 1'b0;
        @(posedge clock_i);
        @(negedge clock_i);
        chk(tx_chan_status_bits_o[7:0], 8'h5A);
        chk(tx_chan_status_bits_o[191:184], 8'hC3);
        chk({7'h0, tx_crc_gen_o}, 8'h00);
        $display("copy test done");
    endtask
    task automatic t_reset;
        rchk(RSX_ADDR_STREAM_STATUS, 8'h10);
        rchk(RSX_ADDR_CLOCK_MODE, 8'hB0);
        rchk(RSX_ADDR_TX_CONTROL, 8'h32);
        $display("reset test done");
    endtask
    task automatic t_change;
        @(posedge clock_i);
        fs_code_i               <= 4'h3;
        subcode_i               <= 80'h1;
        subcode_load_i          <= 1'b1;
        nonlinear_detect_i      <= 1'b1;
        cs_chan_b_i             <= 192'h1;
        cs_crc_err_b_i          <= 1'b1;
        subcode_crc_err_i       <= 1'b1;
        status_channel_select_i <= 1'b1;
        @(posedge clock_i);
        subcode_load_i <= 1'b0;
        rchk(RSX_ADDR_EVENT_STATUS, 8'hC4);
        rchk(RSX_ADDR_STREAM_STATUS, 8'h31);
        rchk(RSX_ADDR_CRC_STATUS, 8'h03);
        $display("change test done");
    endtask
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        {parity_err_i, biphase_err_i, invalid_i, nonlinear_detect_i, cd_surround_detect_i,
            start_id_i, rx_block_start_i, cs_chan_a_i, cs_chan_b_i, cs_crc_err_a_i,
            cs_crc_err_b_i, subcode_load_i, subcode_i, subcode_crc_err_i,
            status_channel_select_i, tx_block_start_i} = '0;
        {mclk_a_i, mclk_b_i, tx_neg_i, pll_locked_i} = 4'hF;
        fs_code_i = 4'h1;
        {irq_mask_a_i, irq_mask_b_i} = 16'hFFFF;
        repeat (5) @(posedge clock_i);
        reset_i <= 1'b0;
        t_reset;
        t_events;
        t_clock;
        t_copy;
        t_change;
        tally_and_finish;
    end
endmodule
`default_nettype wire
